// [hw/main_osc_watch.sv]
// Watches the main oscillator input and flags when its edges stop arriving.
module main_osc_watch
	import osc_ctrl_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic mainOscIn,
	output logic      oscStopped
);

	// All state of the watcher in one record.
	typedef struct packed {
		logic       sync1;   // First synchroniser stage, read only by sync2.
		logic       sync2;   // Second synchroniser stage.
		logic       last;    // Previous synchronised level, for edge finding.
		logic [4:0] silent;  // Cycles since the last edge seen.
		logic       stopped; // Silence has reached the timeout count.
	} watch_t;

	watch_t cur_r;
	watch_t cur_nxt;

	// The count saturates so that a dead clock keeps the flag up for good.
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.sync1 = mainOscIn;
		cur_nxt.sync2 = cur_r.sync1;
		cur_nxt.last = cur_r.sync2;
		if (cur_r.sync2 != cur_r.last) begin
			// Any edge proves the main clock alive.
			cur_nxt.silent = 5'h00;
		end else if (cur_r.silent != STOP_TIMEOUT_COUNT) begin
			cur_nxt.silent = cur_r.silent + 5'h01;
		end
		cur_nxt.stopped = (cur_nxt.silent == STOP_TIMEOUT_COUNT);
	end

	// Register the record.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign oscStopped = cur_r.stopped;

endmodule

// [hw/onchip_oscillator_enable_control.sv]
// Enable control for the high-speed and low-speed on-chip oscillators.
//
// Behaviour
// - Control bit 0 turns high-speed oscillator on.
// - Reset leaves high-speed oscillator stopped, register zero.
// - Normal mode: high-speed oscillator follows enable bit.
// - Select 11b forces on; stop mode forces off.
// - Control bit 1 stops low-speed oscillator.
// - Unforced low-speed oscillator follows mode and select.
// - Protect mode or watchdog 11b forces low-speed on.
// - Main clock failure starts low-speed, switches base.
// - Control register writable only with protect bit set.
//
// Implementation choice: the address-and-strobe port.
module onchip_oscillator_enable_control
	import osc_ctrl_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [7:0] address,
	input  wire logic [7:0] writeData,
	input  wire logic       writeStrobe,
	input  wire logic       readStrobe,
	output logic      [7:0] readData,
	input  wire logic       mainOscIn,
	output logic            hsOscRun,
	output logic            lsOscRun,
	output logic            baseClockFallback
);

	// All state of the block in one record.
	typedef struct packed {
		logic [7:0] writeProtect;  // Clock protect bit in bit 0.
		logic [7:0] oscControl;    // Enable and stop bits of the oscillators.
		logic [7:0] sysClock;      // High-speed clock source select.
		logic [7:0] clockStop;     // Stop mode and base clock select.
		logic [7:0] stopDetect;    // Detection enable; flag is held apart.
		logic [7:0] watchdog;      // Watchdog control bits 7:6.
		logic [7:0] countProtect;  // Count source protect on in bit 7.
		logic       fallback;      // Base clock moved to the low-speed oscillator.
		logic [7:0] readData;      // Read answer, valid the cycle after the strobe.
		logic       hsRun;         // High-speed oscillator run request.
		logic       lsRun;         // Low-speed oscillator run request.
	} state_t;

	state_t cur_r;
	state_t cur_nxt;
	logic   oscStopped;            // Main clock has gone quiet.

	// Main clock watcher; it synchronises the pin itself.
	main_osc_watch watch (
		.clock      (clock),
		.resetn     (resetn),
		.mainOscIn  (mainOscIn),
		.oscStopped (oscStopped)
	);

	// High-speed decision from stop mode, the two-bit select and the enable.
	function automatic logic hsDecide(input state_t s);
		logic [1:0] sel;
		sel = {s.sysClock[HS_CLOCK_SOURCE_POS], s.clockStop[BASE_CLOCK_SELECT_POS]};
		if (s.clockStop[STOP_MODE_POS]) begin
			hsDecide = 1'b0;
		end else if (sel == 2'b11) begin
			hsDecide = 1'b1;
		end else begin
			hsDecide = s.oscControl[HS_OSC_ENABLE_POS];
		end
	endfunction

	// Low-speed decision; the forcing terms override every other setting.
	function automatic logic lsDecide(input state_t s);
		logic forced;
		forced = s.countProtect[COUNT_PROTECT_ON_POS]
			| (s.watchdog[WATCHDOG_BIT7_POS] & s.watchdog[WATCHDOG_BIT6_POS]);
		if (forced || s.fallback) begin
			lsDecide = 1'b1;
		end else if (s.clockStop[STOP_MODE_POS]) begin
			lsDecide = 1'b0;
		end else if (!s.clockStop[BASE_CLOCK_SELECT_POS]) begin
			lsDecide = 1'b1;
		end else begin
			lsDecide = !s.oscControl[LS_OSC_STOP_POS];
		end
	endfunction

	// Register writes, the read answer, fallback and the run decisions.
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.readData = READ_UNMAPPED;
		if (writeStrobe) begin
			case (address)
				ADDR_WRITE_PROTECT: begin
					cur_nxt.writeProtect = writeData & WRITE_PROTECT_MASK;
				end
				ADDR_OSC_CONTROL: begin
					// A write without the protect bit is dropped silently.
					if (cur_r.writeProtect[CLOCK_PROTECT_BIT0_POS]) begin
						cur_nxt.oscControl = writeData & OSC_CONTROL_MASK;
					end
				end
				ADDR_SYS_CLOCK: begin
					cur_nxt.sysClock = writeData & SYS_CLOCK_MASK;
				end
				ADDR_CLOCK_STOP: begin
					cur_nxt.clockStop = writeData & CLOCK_STOP_MASK;
				end
				ADDR_STOP_DETECT: begin
					cur_nxt.stopDetect[STOP_DETECT_ENABLE_POS] =
						writeData[STOP_DETECT_ENABLE_POS];
				end
				ADDR_WATCHDOG: begin
					cur_nxt.watchdog = writeData & WATCHDOG_MASK;
				end
				ADDR_COUNT_PROTECT: begin
					cur_nxt.countProtect = writeData & COUNT_PROTECT_MASK;
				end
				default: begin
					// Unmapped writes change nothing.
				end
			endcase
		end
		// Failure latches until reset; the clock source must not flip back
		// on its own while software has not yet recovered the main clock.
		if (cur_r.stopDetect[STOP_DETECT_ENABLE_POS] && oscStopped) begin
			cur_nxt.fallback = 1'b1;
		end
		if (readStrobe) begin
			case (address)
				ADDR_WRITE_PROTECT: cur_nxt.readData = cur_r.writeProtect;
				ADDR_OSC_CONTROL:   cur_nxt.readData = cur_r.oscControl;
				ADDR_SYS_CLOCK:     cur_nxt.readData = cur_r.sysClock;
				ADDR_CLOCK_STOP:    cur_nxt.readData = cur_r.clockStop;
				ADDR_STOP_DETECT: begin
					cur_nxt.readData = cur_r.stopDetect;
					cur_nxt.readData[STOP_DETECT_FLAG_POS] = cur_r.fallback;
				end
				ADDR_WATCHDOG:      cur_nxt.readData = cur_r.watchdog;
				ADDR_COUNT_PROTECT: cur_nxt.readData = cur_r.countProtect;
				default:            cur_nxt.readData = READ_UNMAPPED;
			endcase
		end
		// Outputs follow the new settings in the same edge as the write.
		cur_nxt.hsRun = hsDecide(cur_nxt);
		cur_nxt.lsRun = lsDecide(cur_nxt);
	end

	// Register the record; reset stops the high-speed oscillator.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cur_r.writeProtect <= RESET_WRITE_PROTECT;
			cur_r.oscControl   <= RESET_OSC_CONTROL;
			cur_r.sysClock     <= RESET_SYS_CLOCK;
			cur_r.clockStop    <= RESET_CLOCK_STOP;
			cur_r.stopDetect   <= RESET_STOP_DETECT;
			cur_r.watchdog     <= RESET_WATCHDOG;
			cur_r.countProtect <= RESET_COUNT_PROTECT;
			cur_r.fallback     <= 1'b0;
			cur_r.readData     <= READ_UNMAPPED;
			cur_r.hsRun        <= 1'b0;
			cur_r.lsRun        <= 1'b1;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign readData = cur_r.readData;
	assign hsOscRun = cur_r.hsRun;
	assign lsOscRun = cur_r.lsRun;
	assign baseClockFallback = cur_r.fallback;

	// Shorthand views for the checks below.
	logic [1:0] hsSel;
	logic       lsForced;
	logic       ctrlWrite;
	assign hsSel = {cur_r.sysClock[HS_CLOCK_SOURCE_POS], cur_r.clockStop[BASE_CLOCK_SELECT_POS]};
	assign lsForced = cur_r.countProtect[COUNT_PROTECT_ON_POS]
		| (cur_r.watchdog[WATCHDOG_BIT7_POS] & cur_r.watchdog[WATCHDOG_BIT6_POS]);
	assign ctrlWrite = writeStrobe && (address == ADDR_OSC_CONTROL);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// A main clock failure seen while detection is enabled.
	sequence failSeen;
		cur_r.stopDetect[STOP_DETECT_ENABLE_POS] && oscStopped;
	endsequence

	// The fallback and the low-speed run request then stand together.
	sequence fallbackTaken;
		baseClockFallback && lsOscRun;
	endsequence

	AST_HS_ENABLE: assert property (
		ctrlWrite && cur_r.writeProtect[0] && writeData[0] && !cur_r.clockStop[0]
		|=> hsOscRun) else $error("Enable write did not start the high-speed oscillator.");
	AST_HS_FOLLOW: assert property (
		!cur_r.clockStop[STOP_MODE_POS] && hsSel != 2'b11
		|-> hsOscRun == cur_r.oscControl[HS_OSC_ENABLE_POS])
		else $error("High-speed oscillator does not follow its enable.");
	AST_HS_FORCED: assert property (
		!cur_r.clockStop[STOP_MODE_POS] && hsSel == 2'b11 |-> hsOscRun)
		else $error("High-speed oscillator not forced on by select 11b.");
	AST_HS_STOPMODE: assert property (
		cur_r.clockStop[STOP_MODE_POS] |-> !hsOscRun)
		else $error("High-speed oscillator runs in stop mode.");
	AST_LS_STOPBIT: assert property (
		!lsForced && !baseClockFallback && cur_r.clockStop == 8'h02
		|-> lsOscRun == !cur_r.oscControl[LS_OSC_STOP_POS])
		else $error("Low-speed oscillator does not follow its stop bit.");
	AST_LS_TABLE: assert property (
		!lsForced && !baseClockFallback && cur_r.clockStop[STOP_MODE_POS] |-> !lsOscRun)
		else $error("Low-speed oscillator runs in stop mode unforced.");
	AST_LS_FORCED: assert property (
		lsForced |-> lsOscRun)
		else $error("Low-speed oscillator not forced on.");
	AST_FALLBACK: assert property (
		failSeen |=> fallbackTaken [*3])
		else $error("Main clock failure did not move to the low-speed oscillator.");
	AST_PROTECT: assert property (
		ctrlWrite && !cur_r.writeProtect[CLOCK_PROTECT_BIT0_POS] |=> $stable(cur_r.oscControl))
		else $error("Protected control register was written.");
	AST_WRITE_TAKEN: assert property (
		ctrlWrite && cur_r.writeProtect[CLOCK_PROTECT_BIT0_POS]
		|=> cur_r.oscControl == ($past(writeData) & OSC_CONTROL_MASK))
		else $error("Permitted control write was not stored.");
	AST_UNUSED_ZERO: assert property (
		readStrobe && address == ADDR_OSC_CONTROL |=> readData[7:2] == 6'h00)
		else $error("Unimplemented control bits read nonzero.");

endmodule

// [include/osc_ctrl_pkg.sv]
// Shared constants for the on-chip oscillator enable control block.
package osc_ctrl_pkg;

	// Register byte offsets in the special function register space.
	localparam logic [7:0] ADDR_WRITE_PROTECT = 8'h13;
	localparam logic [7:0] ADDR_OSC_CONTROL   = 8'h21;
	localparam logic [7:0] ADDR_SYS_CLOCK     = 8'h22;
	localparam logic [7:0] ADDR_CLOCK_STOP    = 8'h24;
	localparam logic [7:0] ADDR_STOP_DETECT   = 8'h26;
	localparam logic [7:0] ADDR_WATCHDOG      = 8'h33;
	localparam logic [7:0] ADDR_COUNT_PROTECT = 8'h34;

	// Reset values of every register.
	localparam logic [7:0] RESET_WRITE_PROTECT = 8'h00;
	localparam logic [7:0] RESET_OSC_CONTROL   = 8'h00;
	localparam logic [7:0] RESET_SYS_CLOCK     = 8'h00;
	localparam logic [7:0] RESET_CLOCK_STOP    = 8'h00;
	localparam logic [7:0] RESET_STOP_DETECT   = 8'h00;
	localparam logic [7:0] RESET_WATCHDOG      = 8'h40; // Bit 6 leaves reset set.
	localparam logic [7:0] RESET_COUNT_PROTECT = 8'h00;
	localparam logic [7:0] READ_UNMAPPED       = 8'h00;

	// Field positions.
	localparam int CLOCK_PROTECT_BIT0_POS  = 0;
	localparam int HS_OSC_ENABLE_POS       = 0;
	localparam int LS_OSC_STOP_POS         = 1;
	localparam int HS_CLOCK_SOURCE_POS     = 0;
	localparam int STOP_MODE_POS           = 0;
	localparam int BASE_CLOCK_SELECT_POS   = 1;
	localparam int STOP_DETECT_ENABLE_POS  = 0;
	localparam int STOP_DETECT_FLAG_POS    = 1;
	localparam int WATCHDOG_BIT6_POS       = 6;
	localparam int WATCHDOG_BIT7_POS       = 7;
	localparam int COUNT_PROTECT_ON_POS    = 7;

	// Only the two low bits of the oscillator control register exist.
	localparam logic [7:0] OSC_CONTROL_MASK = 8'h03;
	// Writable bits of the other registers.
	localparam logic [7:0] WRITE_PROTECT_MASK = 8'h01;
	localparam logic [7:0] SYS_CLOCK_MASK     = 8'h01;
	localparam logic [7:0] CLOCK_STOP_MASK    = 8'h03;
	localparam logic [7:0] WATCHDOG_MASK      = 8'hc0;
	localparam logic [7:0] COUNT_PROTECT_MASK = 8'h80;

	// Main clock stop detection: silence longer than this is a failure.
	localparam int CLOCK_MHZ          = 25;
	localparam int STOP_TIMEOUT_NS    = 640;
	localparam int STOP_TIMEOUT_CYCLES = (STOP_TIMEOUT_NS * CLOCK_MHZ + 999) / 1000;
	localparam logic [4:0] STOP_TIMEOUT_COUNT = 5'(STOP_TIMEOUT_CYCLES);

endpackage

// [sim/test_onchip_oscillator_enable_control.sv]
// Self-checking bench for the on-chip oscillator enable control block.
module test_onchip_oscillator_enable_control;
	timeunit 1ns;
	timeprecision 1ps;
	import osc_ctrl_pkg::*;

	logic       clock;             // System clock, 40 ns period.
	logic       resetn;            // Asynchronous reset, active low.
	logic [7:0] address;           // Register offset.
	logic [7:0] writeData;         // Write data.
	logic       writeStrobe;       // One-cycle write pulse.
	logic       readStrobe;        // One-cycle read pulse.
	logic [7:0] readData;          // Read answer, one cycle after the read.
	logic       mainOscIn;         // Main oscillator pin.
	logic       hsOscRun;          // High-speed oscillator runs.
	logic       lsOscRun;          // Low-speed oscillator runs.
	logic       baseClockFallback; // Base clock moved to the low-speed oscillator.
	logic       mainOn;            // The main oscillator toggles while this is high.
	int         failCount;         // Mismatches seen.
	int         nTests;            // Comparisons made.
	int         seed;              // Fixed seed keeps every run the same.
	logic [7:0] oscCtl, sysClk, clkStop, wdog, cspMode, got;

	onchip_oscillator_enable_control dut (
		.clock(clock), .resetn(resetn), .address(address), .writeData(writeData),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
		.mainOscIn(mainOscIn), .hsOscRun(hsOscRun), .lsOscRun(lsOscRun),
		.baseClockFallback(baseClockFallback));

	// The clock toggles each half period.
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// A running main oscillator toggles every cycle; a stopped one holds its level.
	// This process alone drives the pin, so it also sets its starting level.
	initial begin
		mainOscIn = 1'b0;
		forever begin
			@(posedge clock);
			if (mainOn)
				mainOscIn <= ~mainOscIn;
		end
	end

	// Expected high-speed state from the mirrored register values.
	function automatic logic expHs();
		if (clkStop[0])
			return 1'b0;
		if ({sysClk[0], clkStop[1]} == 2'b11)
			return 1'b1;
		return oscCtl[0];
	endfunction

	// Expected low-speed state; a failed main clock forces it on.
	function automatic logic expLs(input logic fallback);
		if (fallback || cspMode[7] || wdog[7:6] == 2'b11)
			return 1'b1;
		if (clkStop[0])
			return 1'b0;
		if (!clkStop[1])
			return 1'b1;
		return ~oscCtl[1];
	endfunction

	// Compares an 8-bit value.
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		nTests++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Compares a single flag.
	task automatic cmp1(input string what, input logic exp, input logic seen);
		nTests++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask

	// One write cycle; the strobe is dropped at the next edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		address     <= a;
		writeData   <= d;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
	endtask

	// One read cycle; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		address    <= a;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 v = readData;
	endtask

	// Checks both oscillator outputs once the last edge has settled.
	task automatic cmpRuns(input logic fallback);
		#1;
		cmp1("hsOscRun", expHs(), hsOscRun);
		cmp1("lsOscRun", expLs(fallback), lsOscRun);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("errors %0d checks %0d", failCount, nTests);
		if (failCount == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		#2000000;
		failCount++;
		conclude();
	end

	// Main sequence.
	initial begin
		{address, writeData, writeStrobe, readStrobe} = '0;
		{oscCtl, sysClk, clkStop, wdog, cspMode} = '0;
		wdog = RESET_WATCHDOG;
		failCount = 0;
		nTests = 0;
		seed = 32'h117fe4c8;
		mainOn = 1'b1;
		resetn = 1'b0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		cmpRuns(1'b0);
		rd(ADDR_OSC_CONTROL, got);
		cmp8("osc control after reset", 8'h00, got);
		// Oscillator control writes while the protect bit is clear are dropped.
		wr(ADDR_OSC_CONTROL, 8'h01);
		cmpRuns(1'b0);
		rd(ADDR_OSC_CONTROL, got);
		cmp8("protected write", 8'h00, got);
		wr(ADDR_WRITE_PROTECT, 8'h01);
		// Unimplemented bits read zero.
		wr(ADDR_OSC_CONTROL, 8'hff);
		oscCtl = 8'h03;
		cmpRuns(1'b0);
		rd(ADDR_OSC_CONTROL, got);
		cmp8("osc control masked", 8'h03, got);
		rd(8'h40, got);
		cmp8("unmapped read", READ_UNMAPPED, got);
		// The answer stands for one cycle only, then the port falls back to zero.
		rd(ADDR_OSC_CONTROL, got);
		@(posedge clock);
		#1;
		cmp8("read data after answer", READ_UNMAPPED, readData);
		// Random settings sweep every forcing combination many times over.
		repeat (200) begin
			case ($unsigned($random(seed)) % 5)
				0: begin oscCtl = 8'($random(seed)); wr(ADDR_OSC_CONTROL, oscCtl); end
				1: begin sysClk = 8'($random(seed)); wr(ADDR_SYS_CLOCK, sysClk); end
				2: begin clkStop = 8'($random(seed)); wr(ADDR_CLOCK_STOP, clkStop); end
				3: begin wdog = 8'($random(seed)); wr(ADDR_WATCHDOG, wdog); end
				default: begin cspMode = 8'($random(seed)); wr(ADDR_COUNT_PROTECT, cspMode); end
			endcase
			cmpRuns(1'b0);
		end
		rd(ADDR_OSC_CONTROL, got);
		cmp8("osc control readback", oscCtl & OSC_CONTROL_MASK, got);
		// Every setting that steers the oscillators reads back through its mask.
		rd(ADDR_SYS_CLOCK, got);
		cmp8("sys clock readback", sysClk & SYS_CLOCK_MASK, got);
		rd(ADDR_CLOCK_STOP, got);
		cmp8("clock stop readback", clkStop & CLOCK_STOP_MASK, got);
		rd(ADDR_WATCHDOG, got);
		cmp8("watchdog readback", wdog & WATCHDOG_MASK, got);
		rd(ADDR_COUNT_PROTECT, got);
		cmp8("count protect readback", cspMode & COUNT_PROTECT_MASK, got);
		rd(ADDR_WRITE_PROTECT, got);
		cmp8("write protect readback", 8'h01, got);
		// Leave the low-speed oscillator stopped so a forced start is visible.
		{sysClk, wdog, cspMode} = '0;
		clkStop = 8'h02;
		oscCtl = 8'h02;
		wr(ADDR_SYS_CLOCK, 8'h00);
		wr(ADDR_WATCHDOG, 8'h00);
		wr(ADDR_COUNT_PROTECT, 8'h00);
		wr(ADDR_CLOCK_STOP, clkStop);
		wr(ADDR_OSC_CONTROL, oscCtl);
		cmpRuns(1'b0);
		// With detection off a dead main clock changes nothing.
		mainOn = 1'b0;
		repeat (40) @(posedge clock);
		#1;
		cmp1("fallback while disabled", 1'b0, baseClockFallback);
		mainOn = 1'b1;
		repeat (8) @(posedge clock);
		wr(ADDR_STOP_DETECT, 8'h01);
		mainOn = 1'b0;
		for (int i = 0; i < 60 && baseClockFallback !== 1'b1; i++)
			@(posedge clock);
		#1;
		cmp1("baseClockFallback", 1'b1, baseClockFallback);
		cmpRuns(1'b1);
		rd(ADDR_STOP_DETECT, got);
		cmp8("stop detect flag", 8'h03, got);
		// A second reset restores every reset value and clears the fallback again.
		mainOn = 1'b1;
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		{oscCtl, sysClk, clkStop, wdog, cspMode} = '0;
		wdog = RESET_WATCHDOG;
		cmpRuns(1'b0);
		cmp1("fallback after reset", 1'b0, baseClockFallback);
		rd(ADDR_OSC_CONTROL, got);
		cmp8("osc control after reset", 8'h00, got);
		rd(ADDR_WATCHDOG, got);
		cmp8("watchdog after reset", RESET_WATCHDOG, got);
		conclude();
	end
endmodule
